/* bench/iox_ctl_model.sv */
// Serial bus controller model that drives the expander from the far side
`timescale 1ns/1ps
`default_nettype none
module iox_ctl_model (
  // Serial clock and data pull-down
  output logic scl,
  output logic sda_pull,
  // Resolved data wire
  input wire logic sda
);
  // Quarter of a bus bit; clock high and low phases are two quarters each
  localparam int Q = 650;

  // Bus idles with clock high and data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  // Start, also usable as repeated start with the clock low
  task automatic start_c;
    #Q;
    sda_pull = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_pull = 1'b1;
    #Q;
    scl = 1'b0;
  endtask

  // Stop leaves the clock high and still until the next frame
  task automatic stop_c;
    #Q;
    sda_pull = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_pull = 1'b0;
    #Q;
  endtask

  // One bit: data settles mid low phase, sampled mid high phase
  task automatic bit_c(input logic b, output logic s);
    #Q;
    sda_pull = ~b;
    #Q;
    scl = 1'b1;
    #Q;
    s = sda;
    #Q;
    scl = 1'b0;
  endtask

  // Byte out, most significant bit first, then the target's answer
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], s);
    end
    bit_c(1'b1, s);
    ack = ~s;
  endtask

  // Byte in, then our acknowledge or, on the last byte, a release
  task automatic byte_r(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, s);
      d[i] = s;
    end
    bit_c(last, s);
  endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking testbench of the I2C eight-line I/O expander
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [3:0] ADDR_HI = 4'h3;
  logic clk = 1'b0;
  logic rst_n, reset_pin_n, sda_oe, sda_out, ctl_pull, scl, ack, od_out, od_oe;
  logic [2:0] strap;
  logic [6:0] own;
  logic [7:1] pp_out, pp_oe;
  logic [7:0] ext, cfg, outr, pol, d0, d1;
  wire logic sda;
  wire logic od_in;
  wire logic [7:1] pp_in;
  int err_total, cmp_count, seed;

  // ----------------------------------------------------------------
  // Clock, wires and instances
  // ----------------------------------------------------------------
  always #25 clk = ~clk;

  // Pull-ups on data and line 0; push-pull lines follow whoever drives
  assign sda = (sda_oe ? sda_out : 1'b1) & ~ctl_pull;
  assign od_in = (od_oe ? od_out : 1'b1) & ext[0];
  assign pp_in = (pp_oe & pp_out) | (~pp_oe & ext[7:1]);

  iox_top #(.ADDR_HI(ADDR_HI)) i_dut (
    .clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .open_drain_line_in(od_in), .open_drain_line_out(od_out), .open_drain_line_oe(od_oe),
    .push_pull_line_in(pp_in), .push_pull_line_out(pp_out), .push_pull_line_oe(pp_oe)
  );

  iox_ctl_model i_ctl (.scl(scl), .sda_pull(ctl_pull), .sda(sda));

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Address, then command and one data byte when full is set
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    input logic full, output logic ok);
    logic k;
    i_ctl.start_c;
    i_ctl.byte_w({a, 1'b0}, ok);
    if (ok && full) begin
      i_ctl.byte_w(c, k);
      ok = ok & k;
      i_ctl.byte_w(d, k);
      ok = ok & k;
    end
    i_ctl.stop_c;
  endtask

  // Select by command, repeated start, two bytes of the same register
  task automatic rd(input logic [7:0] c, output logic [7:0] r0, output logic [7:0] r1);
    logic k;
    i_ctl.start_c;
    i_ctl.byte_w({own, 1'b0}, k);
    i_ctl.byte_w(c, k);
    i_ctl.start_c;
    i_ctl.byte_w({own, 1'b1}, k);
    i_ctl.byte_r(1'b0, r0);
    i_ctl.byte_r(1'b1, r1);
    i_ctl.stop_c;
  endtask

  // Model of the input register: wire levels, then inversion
  function automatic logic [7:0] exp_in();
    logic [7:0] lvl;
    lvl[0] = (cfg[0] | outr[0]) & ext[0];
    lvl[7:1] = (cfg[7:1] & ext[7:1]) | (~cfg[7:1] & outr[7:1]);
    return lvl ^ pol;
  endfunction

  // Pins against the model, then every register read back
  task automatic chk_state;
    chk("line oe", {~cfg[7:1], ~cfg[0] & ~outr[0]}, {pp_oe, od_oe});
    chk("line out", {outr[7:1], 1'b0}, {pp_out, od_out});
    chk("od pull", {7'h00, ~cfg[0] & ~outr[0]}, {7'h00, od_oe});
    rd({6'h00, iox_pkg::REG_INPUT}, d0, d1);
    chk("input reg", exp_in(), d0);
    chk("input reg again", exp_in(), d1);
    rd({6'h00, iox_pkg::REG_OUTPUT}, d0, d1);
    chk("output reg", outr, d0);
    rd({6'h00, iox_pkg::REG_POLARITY}, d0, d1);
    chk("polarity reg", pol, d0);
    rd({6'h00, iox_pkg::REG_CONFIG}, d0, d1);
    chk("config reg", cfg, d0);
  endtask

  task automatic model_reset;
    cfg = iox_pkg::CFG_RESET;
    outr = iox_pkg::OUT_RESET;
    pol = iox_pkg::POL_RESET;
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    print_verdict;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h7775D6F8;
    err_total = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    reset_pin_n = 1'b1;
    ext = $random(seed);
    strap = $random(seed);
    own = {ADDR_HI, strap};
    repeat (8) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    // Defaults after power-on: every line an input
    model_reset;
    chk_state;
    // Only the strapped address is acknowledged
    for (int a = 0; a < 8; a++) begin
      wr({ADDR_HI, a[2:0]}, 8'h00, 8'h00, 1'b0, ack);
      chk("address ack", {7'h00, a[2:0] == strap}, {7'h00, ack});
    end
    // Random direction, output and inversion settings
    repeat (3) begin
      @(posedge clk);
      #2 ext = $random(seed);
      cfg = $random(seed);
      outr = $random(seed);
      pol = $random(seed);
      wr(own, {6'h00, iox_pkg::REG_CONFIG}, cfg, 1'b1, ack);
      chk("write ack", 8'h01, {7'h00, ack});
      wr(own, {6'h00, iox_pkg::REG_OUTPUT}, outr, 1'b1, ack);
      wr(own, {6'h00, iox_pkg::REG_POLARITY}, pol, 1'b1, ack);
      // A write to the input register is taken and discarded
      wr(own, {6'h00, iox_pkg::REG_INPUT}, 8'($random(seed)), 1'b1, ack);
      chk("input write ack", 8'h01, {7'h00, ack});
      chk_state;
    end
    // External reset pin restores the defaults mid-run
    @(posedge clk);
    #2 reset_pin_n = 1'b0;
    repeat (6) @(posedge clk);
    #2 reset_pin_n = 1'b1;
    repeat (10) @(posedge clk);
    model_reset;
    chk_state;
    print_verdict;
  end
endmodule
`default_nettype wire

/* rtl/iox_filter.sv */
// Two-flop synchroniser followed by a per-bit spike filter
`timescale 1ns/1ps
`default_nettype none
module iox_filter #(
  parameter int W = 1,
  parameter int FILT = iox_pkg::FILT_CYC,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw and cleaned levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  localparam int CW = $clog2(FILT + 1);

  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] next_clean;
  logic [W-1:0][CW-1:0] cnt;
  logic [W-1:0][CW-1:0] next_cnt;

  // Follow a new level only after it held for FILT samples
  always_comb begin
    next_clean = clean;
    next_cnt = cnt;
    for (int i = 0; i < W; i++) begin
      if (sync[i] == clean[i]) begin
        next_cnt[i] = '0;
      end else if (cnt[i] == CW'(FILT - 1)) begin
        next_clean[i] = sync[i];
        next_cnt[i] = '0;
      end else begin
        next_cnt[i] = cnt[i] + 1'b1;
      end
    end
  end

  // Synchroniser stages and filter state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= INIT;
      sync <= INIT;
      clean <= INIT;
      cnt <= '0;
    end else begin
      meta <= raw;
      sync <= meta;
      clean <= next_clean;
      cnt <= next_cnt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_filter_hold: assert property (
    $changed(clean) |-> ($past(sync) == clean) && ($past(sync, FILT) == clean))
    else $error("filtered level moved before the input settled");
endmodule
`default_nettype wire

/* rtl/iox_link_rx.sv */
// Serial-clock domain shift register for incoming data bits
`timescale 1ns/1ps
`default_nettype none
module iox_link_rx (
  // Link clock
  input wire logic scl,
  // Serial data and the last eight bits seen
  input wire logic sda_in,
  output logic [7:0] rx_shift
);
  logic [7:0] next_rx_shift;

  // Shift one data bit in on each rising serial clock
  always_comb begin
    next_rx_shift = {rx_shift[6:0], sda_in};
  end

  // Pure data path: no reset, the core only reads it at byte ends
  always_ff @(posedge scl) begin
    rx_shift <= next_rx_shift;
  end
endmodule
`default_nettype wire

/* rtl/iox_pkg.sv */
// Shared constants and types of the I2C eight-line I/O expander
package iox_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int SPIKE_NS = 50;
  // Samples an input must differ before the filtered level follows
  localparam int FILT_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int PIN_FILT = 1;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int NLINES = 8;
  localparam int OD_LINE = 0;
  localparam int PTR_W = 2;
  localparam int STRAP_W = 3;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // ----------------------------------------------------------------
  // Register selection by command byte
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_INPUT = 2'h0;
  localparam logic [1:0] REG_OUTPUT = 2'h1;
  localparam logic [1:0] REG_POLARITY = 2'h2;
  localparam logic [1:0] REG_CONFIG = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and address
  // ----------------------------------------------------------------
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [7:0] POL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'hFF;
  localparam logic [7:0] IN_RESET = 8'h00;
  localparam logic [3:0] ADDR_HI_DEF = 4'h3;

  // ----------------------------------------------------------------
  // Protocol states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_MACK = 3'b101,
    ST_ACK_WAIT = 3'b110,
    ST_ACK_HOLD = 3'b111
  } iox_state_t;
endpackage

/* rtl/iox_top.sv */
// I2C eight-line I/O expander core: protocol engine, registers, pins
//
// Behaviour
// - Four eight-bit registers: direction, input, output, polarity inversion.
// - After reset every line is an input and nothing is driven.
// - Direction bit set releases a line, clear drives it.
// - Input register samples lines; output register latches until rewritten.
// - Set polarity bit inverts that line in the input register.
// - Every register reads back over the serial bus.
// - Power-on reset loads defaults and idles the protocol engine.
// - Low reset pin does the same initialisation as power-on.
// - Address uses three straps; only the own address is acknowledged.
// - Open-drain line only pulls low when an output at zero.
// - The other seven lines drive high and low as outputs.
// - Serial clock and data pass a spike filter for bus event detection; received bits shift in on the unfiltered clock and data.
`timescale 1ns/1ps
`default_nettype none
module iox_top #(
  parameter logic [3:0] ADDR_HI = iox_pkg::ADDR_HI_DEF
) (
  // System clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // External reset pin, active low
  input wire logic reset_pin_n,
  // Serial bus: clock and open-drain data
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  // Open-drain I/O line
  input wire logic open_drain_line_in,
  output logic open_drain_line_out,
  output logic open_drain_line_oe,
  // Push-pull I/O lines 7 down to 1
  input wire logic [iox_pkg::NLINES-1:iox_pkg::OD_LINE+1] push_pull_line_in,
  output logic [iox_pkg::NLINES-1:iox_pkg::OD_LINE+1] push_pull_line_out,
  output logic [iox_pkg::NLINES-1:iox_pkg::OD_LINE+1] push_pull_line_oe
);
  localparam int N = iox_pkg::NLINES;
  localparam int OD = iox_pkg::OD_LINE;

  // ----------------------------------------------------------------
  // Pin synchronisers and filters
  // ----------------------------------------------------------------
  logic pin_rst_n_s;
  logic sys_rst_n;
  logic scl_f;
  logic sda_f;
  logic [iox_pkg::STRAP_W-1:0] strap_s;
  logic [N-1:0] line_s;
  logic [6:0] own_addr;

  // External reset pin, brought into the clock domain
  iox_filter #(.W(1), .FILT(iox_pkg::PIN_FILT), .INIT(1'b1)) u_rst_sync (
    .clk(clk),
    .rst_n(rst_n),
    .raw(reset_pin_n),
    .clean(pin_rst_n_s)
  );

  // Either reset source initialises the whole core
  assign sys_rst_n = rst_n & pin_rst_n_s;

  // Serial clock and data, spike filtered; both idle high
  iox_filter #(.W(2), .FILT(iox_pkg::FILT_CYC), .INIT(2'h3)) u_bus_filt (
    .clk(clk),
    .rst_n(sys_rst_n),
    .raw({scl, sda_in}),
    .clean({scl_f, sda_f})
  );

  // Address straps
  iox_filter #(.W(iox_pkg::STRAP_W), .FILT(iox_pkg::PIN_FILT), .INIT(3'h0)) u_strap (
    .clk(clk),
    .rst_n(sys_rst_n),
    .raw({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}),
    .clean(strap_s)
  );

  // I/O line levels
  iox_filter #(.W(N), .FILT(iox_pkg::PIN_FILT), .INIT(iox_pkg::IN_RESET)) u_lines (
    .clk(clk),
    .rst_n(sys_rst_n),
    .raw({push_pull_line_in, open_drain_line_in}),
    .clean(line_s)
  );

  // Fixed upper bits with the strap-selected low bits
  assign own_addr = {ADDR_HI, strap_s};

  // ----------------------------------------------------------------
  // Link clock domain receiver
  // ----------------------------------------------------------------
  logic [7:0] rx_shift;

  // Bits shift in on the serial clock itself; the core reads the word
  // only after the filtered clock rose, when it is quiet for a full
  // clock-high phase, so the filtered edge acts as the crossing qualifier
  iox_link_rx u_link (
    .scl(scl),
    .sda_in(sda_in),
    .rx_shift(rx_shift)
  );

  // ----------------------------------------------------------------
  // Bus event detection
  // ----------------------------------------------------------------
  logic scl_d;
  logic sda_d;
  logic next_scl_d;
  logic next_sda_d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Previous filtered levels
  always_comb begin
    next_scl_d = scl_f;
    next_sda_d = sda_f;
  end

  always_ff @(posedge clk) begin
    if (!sys_rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= next_scl_d;
      sda_d <= next_sda_d;
    end
  end

  // Edges, and data changes while the clock is high
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign bus_start = scl_f & scl_d & sda_d & ~sda_f;
  assign bus_stop = scl_f & scl_d & ~sda_d & sda_f;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [N-1:0] in_reg;
  logic [N-1:0] out_reg;
  logic [N-1:0] pol;
  logic [N-1:0] cfg;
  logic [N-1:0] next_in_reg;
  logic [N-1:0] next_out_reg;
  logic [N-1:0] next_pol;
  logic [N-1:0] next_cfg;
  logic [N-1:0] read_data;
  logic wr_en;
  logic [iox_pkg::PTR_W-1:0] ptr;

  // Sampled levels with per-line inversion, and write decode
  always_comb begin
    next_in_reg = line_s ^ pol;
    next_out_reg = out_reg;
    next_pol = pol;
    next_cfg = cfg;
    if (wr_en) begin
      unique case (ptr)
        iox_pkg::REG_INPUT: next_out_reg = out_reg; // read-only
        iox_pkg::REG_OUTPUT: next_out_reg = rx_shift;
        iox_pkg::REG_POLARITY: next_pol = rx_shift;
        iox_pkg::REG_CONFIG: next_cfg = rx_shift;
      endcase
    end
  end

  // Registers with their defaults under either reset
  always_ff @(posedge clk) begin
    if (!sys_rst_n) begin
      in_reg <= iox_pkg::IN_RESET;
      out_reg <= iox_pkg::OUT_RESET;
      pol <= iox_pkg::POL_RESET;
      cfg <= iox_pkg::CFG_RESET;
    end else begin
      in_reg <= next_in_reg;
      out_reg <= next_out_reg;
      pol <= next_pol;
      cfg <= next_cfg;
    end
  end

  // Read-back selection
  always_comb begin
    unique case (ptr)
      iox_pkg::REG_INPUT: read_data = in_reg;
      iox_pkg::REG_OUTPUT: read_data = out_reg;
      iox_pkg::REG_POLARITY: read_data = pol;
      iox_pkg::REG_CONFIG: read_data = cfg;
    endcase
  end

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  iox_pkg::iox_state_t state;
  iox_pkg::iox_state_t next_state;
  iox_pkg::iox_state_t after_ack;
  iox_pkg::iox_state_t next_after_ack;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [iox_pkg::PTR_W-1:0] next_ptr;
  logic [7:0] tx_shift;
  logic [7:0] next_tx_shift;
  logic sda_drv;
  logic next_sda_drv;
  logic byte_done;
  logic in_byte;

  assign in_byte = (state == iox_pkg::ST_ADDR) || (state == iox_pkg::ST_CMD) ||
                   (state == iox_pkg::ST_WDATA) || (state == iox_pkg::ST_RDATA);
  assign byte_done = in_byte && scl_rise && (bitcnt == iox_pkg::LAST_BIT);

  // Byte framing, acknowledge slots and data shifting
  always_comb begin
    next_state = state;
    next_after_ack = after_ack;
    next_bitcnt = bitcnt;
    next_ptr = ptr;
    next_tx_shift = tx_shift;
    next_sda_drv = sda_drv;
    wr_en = 1'b0;
    if (bus_stop) begin
      next_state = iox_pkg::ST_IDLE;
      next_sda_drv = 1'b0;
    end else if (bus_start) begin
      // A repeated start restarts framing but keeps the pointer
      next_state = iox_pkg::ST_ADDR;
      next_bitcnt = '0;
      next_sda_drv = 1'b0;
    end else begin
      if (in_byte && scl_rise) begin
        next_bitcnt = bitcnt + 4'h1;
      end
      unique case (state)
        iox_pkg::ST_IDLE: next_state = iox_pkg::ST_IDLE;
        iox_pkg::ST_ADDR: begin
          if (byte_done) begin
            next_bitcnt = '0;
            if (rx_shift[7:1] == own_addr) begin
              next_state = iox_pkg::ST_ACK_WAIT;
              next_after_ack = rx_shift[0] ? iox_pkg::ST_RDATA : iox_pkg::ST_CMD;
            end else begin
              next_state = iox_pkg::ST_IDLE;
            end
          end
        end
        iox_pkg::ST_CMD: begin
          if (byte_done) begin
            next_bitcnt = '0;
            next_ptr = rx_shift[iox_pkg::PTR_W-1:0];
            next_state = iox_pkg::ST_ACK_WAIT;
            next_after_ack = iox_pkg::ST_WDATA;
          end
        end
        iox_pkg::ST_WDATA: begin
          if (byte_done) begin
            next_bitcnt = '0;
            wr_en = 1'b1;
            next_state = iox_pkg::ST_ACK_WAIT;
          end
        end
        iox_pkg::ST_RDATA: begin
          if (byte_done) begin
            next_bitcnt = '0;
            next_state = iox_pkg::ST_MACK;
          end else if (scl_fall) begin
            next_tx_shift = {tx_shift[6:0], 1'b0};
            next_sda_drv = ~tx_shift[6];
          end
        end
        iox_pkg::ST_MACK: begin
          // Release data, then sample the controller's acknowledge
          if (scl_fall) begin
            next_sda_drv = 1'b0;
          end else if (scl_rise) begin
            next_state = sda_f ? iox_pkg::ST_IDLE : iox_pkg::ST_ACK_HOLD;
          end
        end
        iox_pkg::ST_ACK_WAIT: begin
          if (scl_fall) begin
            next_sda_drv = 1'b1;
            next_state = iox_pkg::ST_ACK_HOLD;
          end
        end
        iox_pkg::ST_ACK_HOLD: begin
          if (scl_fall) begin
            next_state = after_ack;
            if (after_ack == iox_pkg::ST_RDATA) begin
              next_tx_shift = read_data;
              next_sda_drv = ~read_data[7];
            end else begin
              next_sda_drv = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Engine state; returns to idle under either reset
  always_ff @(posedge clk) begin
    if (!sys_rst_n) begin
      state <= iox_pkg::ST_IDLE;
      after_ack <= iox_pkg::ST_CMD;
      bitcnt <= '0;
      ptr <= iox_pkg::REG_INPUT;
      tx_shift <= '0;
      sda_drv <= 1'b0;
    end else begin
      state <= next_state;
      after_ack <= next_after_ack;
      bitcnt <= next_bitcnt;
      ptr <= next_ptr;
      tx_shift <= next_tx_shift;
      sda_drv <= next_sda_drv;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Serial data only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = sda_drv;

  // Open-drain line: pulled low only as an output at zero
  assign open_drain_line_out = 1'b0;
  assign open_drain_line_oe = ~cfg[OD] & ~out_reg[OD];

  // Push-pull lines follow the latched output when enabled
  assign push_pull_line_out = out_reg[N-1:OD+1];
  assign push_pull_line_oe = ~cfg[N-1:OD+1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!sys_rst_n);

  sequence s_addr_hit;
    (state == iox_pkg::ST_ADDR) && byte_done && (rx_shift[7:1] == own_addr);
  endsequence

  sequence s_ack_slot;
    (state == iox_pkg::ST_ACK_WAIT) && scl_fall;
  endsequence

  sequence s_read_load;
    (state == iox_pkg::ST_ACK_HOLD) && (after_ack == iox_pkg::ST_RDATA) && scl_fall;
  endsequence

  chk_por_idle: assert property (@(posedge clk) disable iff (1'b0)
    !rst_n |=> (state == iox_pkg::ST_IDLE) && (cfg == iox_pkg::CFG_RESET) && !sda_oe)
    else $error("power-on reset did not idle the core");

  chk_pin_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !pin_rst_n_s |=> (state == iox_pkg::ST_IDLE) && (out_reg == iox_pkg::OUT_RESET)
                     && (pol == iox_pkg::POL_RESET))
    else $error("reset pin did not restore defaults");

  chk_cfg_input: assert property (@(posedge clk) disable iff (1'b0)
    !sys_rst_n |=> (push_pull_line_oe == '0) && !open_drain_line_oe)
    else $error("a line is driven after reset");

  chk_dir_write: assert property (
    wr_en && (ptr == iox_pkg::REG_CONFIG) |=> push_pull_line_oe == ~$past(rx_shift[N-1:OD+1]))
    else $error("direction write not reflected on enables");

  chk_out_latch: assert property (
    !wr_en |=> $stable(out_reg))
    else $error("output register changed without a write");

  chk_pol_view: assert property (
    1'b1 |=> in_reg == ($past(line_s) ^ $past(pol)))
    else $error("input register ignores polarity");

  chk_read_load: assert property (
    s_read_load |=> (tx_shift == $past(read_data)) && (sda_drv == !$past(read_data[7])))
    else $error("read byte not loaded onto data line");

  chk_addr_ack: assert property (
    s_addr_hit ##1 (!bus_start && !bus_stop) [*1] ##0 (state == iox_pkg::ST_ACK_WAIT)
      |-> ##[1:400] (s_ack_slot or bus_start or bus_stop))
    else $error("own address not answered");

  chk_ack_drive: assert property (
    s_ack_slot |=> sda_drv [*1] ##0 (state == iox_pkg::ST_ACK_HOLD))
    else $error("acknowledge not driven");

  chk_addr_miss: assert property (
    (state == iox_pkg::ST_ADDR) && byte_done && (rx_shift[7:1] != own_addr)
      |=> (state == iox_pkg::ST_IDLE) && !sda_drv)
    else $error("foreign address acknowledged");

  chk_od_low: assert property (
    open_drain_line_oe |-> !cfg[OD] && !out_reg[OD] && !open_drain_line_out)
    else $error("open-drain line driven high or as input");

  chk_pp_drive: assert property (
    wr_en && (ptr == iox_pkg::REG_OUTPUT) |=> push_pull_line_out == $past(rx_shift[N-1:OD+1]))
    else $error("push-pull lines ignore output write");
endmodule
`default_nettype wire
